// [design/ssi_core.sv]
// How it works
// - Master: data write starts transfer automatically
// - Slave: each clock shifts buffer out/in
// - Disabled interface releases all SPI pins
// - Clock, in, out, active-low select lines
// - Select enable low disables SPI, select floats
// - Enabled idle: input floats, output high, except a selected slave drives its first buffer bit
// - Master idle clock level is the inverse of the polarity bit
// - Slave: clock pin is input from master
// - Master makes clock only after data write
// - Received byte copied to data when complete
// - Transfer end sets complete flag
// - Write while busy blocked, sets collision flag
// - Both ends use the same bit order
// - I2C lines are open-drain
// - I2C clock debounce of 2 or 4 clocks
// - Pull-up control stays usable under I2C
// - Mode field picks clock source or role
// - Polarity and edge bits pick capture edge
// - Early select release sets incomplete, complete
// - Debounce field: off, two, four clocks
`timescale 1ns/1ps
module ssi_core (
   input  wire logic        mclk,
   input  wire logic        rst,
   input  wire logic        ce,
   input  wire logic [4:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   input  wire logic        serialClockIn,
   output logic             serialClockOut,
   output logic             serialClockOe,
   input  wire logic        serialIn,
   output logic             serialOut,
   output logic             serialOutOe,
   input  wire logic        selectLineNIn,
   output logic             selectLineNOut,
   output logic             selectLineNOe,
   input  wire logic        sclIn,
   output logic             sclOut,
   output logic             sclOe,
   input  wire logic        sdaIn,
   output logic             sdaOut,
   output logic             sdaOe,
   output logic             sclPullUp,
   output logic             sdaPullUp,
   input  wire logic        subClk,
   input  wire logic        timerPeriodMatch
);
   logic [7:0]  mode_q, stat_q, ctl2_q, toc_q, buf_q, rd_q;
   logic [1:0]  pull_q;
   logic        waitReq_q;
   logic [31:0] rdData_q, rdMux;
   logic [5:0]  sA_q, sB_q, sC_q;
   ssi_pkg::ssi_state_t st_q;
   logic [3:0]  edge_q;
   logic [2:0]  bitCnt_q, debCnt_q, debLast;
   logic [4:0]  div_q, divLast;
   logic        sck_q, sdo_q, sel_q, sckOe_q, sdoOe_q, selOe_q;
   logic        sclF_q;
   logic [2:0]  md;
   logic        en, select_pin_enable, bit_order_select, clock_edge_select, ckpol, master, spiOn, i2cOn;
   logic        wrEv, wrData, busy, collide, mStart, tick, mEdge;
   logic        mCap, mLaunch, mDone, capRise, selected;
   logic        sRise, sFall, sCap, sLaunch, sDone, sAbort, cap;
   logic        idleLvl, sdiBit, firstBuf, firstWr;
   logic [7:0]  nextBuf, wdata8;

   assign md      = mode_q[ssi_pkg::B_MDH:ssi_pkg::B_MDL];
   assign en      = mode_q[ssi_pkg::B_EN];
   assign select_pin_enable    = ctl2_q[ssi_pkg::B_SELECT_PIN_ENABLE];
   assign bit_order_select     = ctl2_q[ssi_pkg::B_MLS];
   assign clock_edge_select    = ctl2_q[ssi_pkg::B_CLOCK_EDGE_SELECT];
   assign ckpol   = ctl2_q[ssi_pkg::B_CKPOL];
   assign master  = md < ssi_pkg::MD_SLV;
   assign spiOn   = en && select_pin_enable && md != ssi_pkg::MD_I2C
                    && md != ssi_pkg::MD_NONE;
   assign i2cOn   = en && md == ssi_pkg::MD_I2C;
   assign idleLvl = !ckpol;
   assign wdata8  = avs_writedata[7:0];
   assign busy    = st_q == ssi_pkg::ST_RUN;

   // Avalon slave: waitrequest drops for one cycle per request
   assign wrEv   = avs_write && !waitReq_q && avs_byteenable[0];
   assign wrData = wrEv && avs_address == ssi_pkg::A_DATA;

   always_comb begin
      unique case (avs_address)
         ssi_pkg::A_MODE: rdMux = {24'h0, mode_q};
         ssi_pkg::A_STAT: rdMux = {24'h0, stat_q};
         ssi_pkg::A_DATA: rdMux = {24'h0, rd_q};
         ssi_pkg::A_CTL2: rdMux = {24'h0, ctl2_q};
         ssi_pkg::A_TOC:  rdMux = {24'h0, toc_q};
         ssi_pkg::A_PULL: rdMux = {30'h0, pull_q};
         ssi_pkg::A_PIN:  rdMux = {30'h0, sB_q[4], sclF_q};
         default:         rdMux = ssi_pkg::RD_NONE;
      endcase
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         waitReq_q <= 1'b1;
         rdData_q  <= ssi_pkg::RD_NONE;
      end else if (ce) begin
         if (waitReq_q && (avs_read || avs_write)) begin
            waitReq_q <= 1'b0;
            rdData_q  <= avs_read ? rdMux : ssi_pkg::RD_NONE;
         end else begin
            waitReq_q <= 1'b1;
         end
      end
   end
   assign avs_waitrequest = waitReq_q;
   assign avs_readdata    = rdData_q;

   // Pin synchronisers: clock, select, in, sub clock, sda, scl
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         sA_q <= 6'h3F;
         sB_q <= 6'h3F;
         sC_q <= 6'h3F;
      end else if (ce) begin
         sA_q <= {sclIn, sdaIn, subClk, serialIn, selectLineNIn,
                  serialClockIn};
         sB_q <= sA_q;
         sC_q <= sB_q;
      end
   end

   assign sdiBit   = sB_q[2];
   assign nextBuf  = bit_order_select ? {buf_q[6:0], sdiBit}
                         : {sdiBit, buf_q[7:1]};
   assign firstBuf = bit_order_select ? buf_q[7] : buf_q[0];
   assign firstWr  = bit_order_select ? wdata8[7] : wdata8[0];

   // Master clock source
   always_comb begin
      unique case (md)
         ssi_pkg::MD_DIV16: divLast = ssi_pkg::DIV16_LAST;
         ssi_pkg::MD_DIV64: divLast = ssi_pkg::DIV64_LAST;
         default:           divLast = ssi_pkg::DIV4_LAST;
      endcase
      unique case (md)
         ssi_pkg::MD_SUB: tick = sB_q[3] ^ sC_q[3];
         ssi_pkg::MD_TMR: tick = timerPeriodMatch;
         default:         tick = div_q == divLast;
      endcase
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         div_q <= 5'h00;
      end else if (ce) begin
         if (!(master && busy) || div_q == divLast) begin
            div_q <= 5'h00;
         end else begin
            div_q <= div_q + 5'h01;
         end
      end
   end

   // Master events: even edge index is the leading edge
   assign mStart  = wrData && !busy && master && spiOn;
   assign mEdge   = busy && master && tick;
   assign mCap    = mEdge && (edge_q[0] == !clock_edge_select);
   assign mLaunch = mEdge && !mCap && edge_q != 4'h0;
   assign mDone   = mEdge && edge_q == ssi_pkg::LAST_EDGE;

   // Slave events from the synchronised clock pin
   assign capRise  = ckpol == clock_edge_select;
   assign selected = !master && spiOn && !sB_q[1];
   assign sRise    = sB_q[0] && !sC_q[0];
   assign sFall    = !sB_q[0] && sC_q[0];
   assign sCap     = selected && (capRise ? sRise : sFall);
   assign sLaunch  = selected && (capRise ? sFall : sRise);
   assign sDone    = sCap && busy
                     && bitCnt_q == ssi_pkg::LAST_BIT;
   assign sAbort   = busy && !master && spiOn && sB_q[1];
   assign cap      = mCap || sCap;
   assign collide  = wrData && busy;

   // Transfer engine
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         st_q     <= ssi_pkg::ST_IDLE;
         buf_q    <= 8'h00;
         rd_q     <= 8'h00;
         edge_q   <= 4'h0;
         bitCnt_q <= 3'h0;
      end else if (ce) begin
         if (!spiOn || sAbort) begin
            st_q     <= ssi_pkg::ST_IDLE;
            edge_q   <= 4'h0;
            bitCnt_q <= 3'h0;
            if (wrData && !busy) begin
               buf_q <= wdata8;
            end
         end else begin
            unique case (st_q)
               ssi_pkg::ST_IDLE: begin
                  edge_q <= 4'h0;
                  if (wrData) begin
                     buf_q <= wdata8;
                  end
                  if (mStart) begin
                     st_q <= ssi_pkg::ST_RUN;
                  end else if (sCap) begin
                     st_q     <= ssi_pkg::ST_RUN;
                     buf_q    <= nextBuf;
                     bitCnt_q <= 3'h1;
                  end
               end
               ssi_pkg::ST_RUN: begin
                  if (cap) begin
                     buf_q <= nextBuf;
                  end
                  if (mEdge) begin
                     edge_q <= edge_q + 4'h1;
                  end
                  if (sCap) begin
                     bitCnt_q <= bitCnt_q + 3'h1;
                  end
                  if (mDone || sDone) begin
                     st_q     <= ssi_pkg::ST_IDLE;
                     bitCnt_q <= 3'h0;
                     rd_q     <= cap ? nextBuf : buf_q;
                  end
               end
            endcase
         end
      end
   end

   // SPI pin drivers and enables
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         sck_q   <= 1'b1;
         sdo_q   <= 1'b1;
         sel_q   <= 1'b1;
         sckOe_q <= 1'b0;
         sdoOe_q <= 1'b0;
         selOe_q <= 1'b0;
      end else if (ce) begin
         sckOe_q <= spiOn && master;
         sdoOe_q <= spiOn;
         selOe_q <= spiOn && master;
         sel_q   <= !(master && busy && spiOn);
         if (mEdge && spiOn) begin
            sck_q <= !sck_q;
         end else if (!busy || !master) begin
            sck_q <= idleLvl;
         end
         if (!spiOn) begin
            sdo_q <= 1'b1;
         end else if (mStart) begin
            sdo_q <= firstWr;
         end else if (busy && (mLaunch || sLaunch)) begin
            sdo_q <= firstBuf;
         end else if (!busy) begin
            sdo_q <= selected ? firstBuf : 1'b1;
         end
      end
   end
   assign serialClockOut = sck_q;
   assign serialClockOe  = sckOe_q;
   assign serialOut      = sdo_q;
   assign serialOutOe    = sdoOe_q;
   assign selectLineNOut = sel_q;
   assign selectLineNOe  = selOe_q;

   // Register file; hardware set wins over software clear
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         mode_q <= ssi_pkg::MODE_RST;
         stat_q <= ssi_pkg::STAT_RST;
         ctl2_q <= ssi_pkg::CTL2_RST;
         toc_q  <= ssi_pkg::TOC_RST;
         pull_q <= ssi_pkg::PULL_RST;
      end else if (ce) begin
         if (wrEv && avs_address == ssi_pkg::A_MODE) begin
            mode_q <= wdata8 & ssi_pkg::MODE_WMASK;
         end
         if (wrEv && avs_address == ssi_pkg::A_STAT) begin
            stat_q <= (stat_q & ~ssi_pkg::STAT_WMASK)
                      | (wdata8 & ssi_pkg::STAT_WMASK);
         end
         if (wrEv && avs_address == ssi_pkg::A_CTL2) begin
            ctl2_q <= wdata8;
         end
         if (wrEv && avs_address == ssi_pkg::A_TOC) begin
            toc_q <= wdata8;
         end
         if (wrEv && avs_address == ssi_pkg::A_PULL) begin
            pull_q <= wdata8[1:0];
         end
         if (sAbort) begin
            mode_q[ssi_pkg::B_ICF] <= 1'b1;
         end
         if (mDone || sDone || sAbort) begin
            ctl2_q[ssi_pkg::B_TRF] <= 1'b1;
         end
         if (collide) begin
            ctl2_q[ssi_pkg::B_WRITE_COLLISION_FLAG] <= 1'b1;
         end
      end
   end
   assign sclPullUp = pull_q[0];
   assign sdaPullUp = pull_q[1];

   // I2C clock debounce
   always_comb begin
      debLast = (mode_q[ssi_pkg::B_DEBH:ssi_pkg::B_DEBL]
                 == ssi_pkg::DEB_TWO) ? ssi_pkg::DEB2_LAST
                                      : ssi_pkg::DEB4_LAST;
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         sclF_q   <= 1'b1;
         debCnt_q <= 3'h0;
      end else if (ce) begin
         if (mode_q[ssi_pkg::B_DEBH:ssi_pkg::B_DEBL]
             == ssi_pkg::DEB_OFF || !i2cOn) begin
            sclF_q   <= sB_q[5];
            debCnt_q <= 3'h0;
         end else if (sB_q[5] == sclF_q) begin
            debCnt_q <= 3'h0;
         end else if (debCnt_q == debLast) begin
            sclF_q   <= sB_q[5];
            debCnt_q <= 3'h0;
         end else begin
            debCnt_q <= debCnt_q + 3'h1;
         end
      end
   end

   // Open-drain lines: always released, low level held on both outputs
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         sclOut <= 1'b0;
         sdaOut <= 1'b0;
         sclOe  <= 1'b0;
         sdaOe  <= 1'b0;
      end else if (ce) begin
         sclOut <= 1'b0;
         sdaOut <= 1'b0;
         sclOe  <= 1'b0;
         sdaOe  <= 1'b0;
      end
   end

   AST_START: assert property (@(posedge mclk) disable iff (rst)
      ce && mStart |=> busy && sdo_q == $past(firstWr))
      else $error("master write did not start transfer");
   AST_MDONE: assert property (@(posedge mclk) disable iff (rst)
      ce && mDone |=> ctl2_q[ssi_pkg::B_TRF] && !busy)
      else $error("complete flag not set at end");
   AST_WRITE_COLLISION_FLAG: assert property (@(posedge mclk) disable iff (rst)
      ce && collide |=> ctl2_q[ssi_pkg::B_WRITE_COLLISION_FLAG]
      && rd_q == $past(rd_q) || $past(mDone))
      else $error("collision not flagged");
   AST_WKEEP: assert property (@(posedge mclk) disable iff (rst)
      $fell(ctl2_q[ssi_pkg::B_WRITE_COLLISION_FLAG]) |->
      $past(wrEv && avs_address == ssi_pkg::A_CTL2))
      else $error("collision flag cleared by hardware");
   AST_OFF: assert property (@(posedge mclk) disable iff (rst)
      ce && !spiOn |=> !sdoOe_q && !sckOe_q && !selOe_q)
      else $error("pins not released when off");
   AST_SDOIDLE: assert property (@(posedge mclk) disable iff (rst)
      ce && spiOn && master && !busy && !mStart |=> sdo_q)
      else $error("idle output not high");
   AST_SLVCK: assert property (@(posedge mclk) disable iff (rst)
      ce && !master |=> !sckOe_q)
      else $error("slave drives clock");
   AST_ABORT: assert property (@(posedge mclk) disable iff (rst)
      ce && sAbort |=> mode_q[ssi_pkg::B_ICF]
      && ctl2_q[ssi_pkg::B_TRF] && !busy)
      else $error("early select release not flagged");
   AST_RDONLY: assert property (@(posedge mclk) disable iff (rst)
      rd_q != $past(rd_q) |-> $past(mDone || sDone))
      else $error("data register changed mid transfer");
   AST_SCKIDLE: assert property (@(posedge mclk) disable iff (rst)
      ce && master && !busy ##1 ce |-> sck_q == $past(idleLvl))
      else $error("idle clock level wrong");
   AST_DEB4: assert property (@(posedge mclk) disable iff (rst)
      i2cOn && mode_q[ssi_pkg::B_DEBH] && sclF_q != $past(sclF_q)
      |-> $past(sB_q[5], 1) == $past(sB_q[5], 4))
      else $error("debounce passed short pulse");

   COV_MDONE: cover property (@(posedge mclk) mDone);
   COV_SDONE: cover property (@(posedge mclk) sDone);
   COV_ABORT: cover property (@(posedge mclk) sAbort);
   COV_COLL:  cover property (@(posedge mclk) collide);
endmodule

// [design/ssi_pkg.sv]
package ssi_pkg;
   // Register byte offsets on the Avalon-MM slave
   localparam logic [4:0] A_MODE = 5'h00;
   localparam logic [4:0] A_STAT = 5'h04;
   localparam logic [4:0] A_DATA = 5'h08;
   localparam logic [4:0] A_CTL2 = 5'h0C;
   localparam logic [4:0] A_TOC  = 5'h10;
   localparam logic [4:0] A_PULL = 5'h14;
   localparam logic [4:0] A_PIN  = 5'h18;

   localparam logic [7:0]  MODE_RST   = 8'hE0;
   localparam logic [7:0]  MODE_WMASK = 8'hEF;
   localparam logic [7:0]  STAT_RST   = 8'h81;
   localparam logic [7:0]  STAT_WMASK = 8'h1A;
   localparam logic [7:0]  CTL2_RST   = 8'h00;
   localparam logic [7:0]  TOC_RST    = 8'h00;
   localparam logic [1:0]  PULL_RST   = 2'h0;
   localparam logic [31:0] RD_NONE    = 32'h0000_0000;

   // mode_control fields
   localparam int unsigned B_ICF  = 0;
   localparam int unsigned B_EN   = 1;
   localparam int unsigned B_DEBL = 2;
   localparam int unsigned B_DEBH = 3;
   localparam int unsigned B_MDL  = 5;
   localparam int unsigned B_MDH  = 7;
   // spi_control fields
   localparam int unsigned B_TRF   = 0;
   localparam int unsigned B_WRITE_COLLISION_FLAG  = 1;
   localparam int unsigned B_SELECT_PIN_ENABLE  = 2;
   localparam int unsigned B_MLS   = 3;
   localparam int unsigned B_CLOCK_EDGE_SELECT  = 4;
   localparam int unsigned B_CKPOL = 5;

   localparam logic [2:0] MD_DIV4  = 3'h0;
   localparam logic [2:0] MD_DIV16 = 3'h1;
   localparam logic [2:0] MD_DIV64 = 3'h2;
   localparam logic [2:0] MD_SUB   = 3'h3;
   localparam logic [2:0] MD_TMR   = 3'h4;
   localparam logic [2:0] MD_SLV   = 3'h5;
   localparam logic [2:0] MD_I2C   = 3'h6;
   localparam logic [2:0] MD_NONE  = 3'h7;

   // Half-period counts minus one
   localparam logic [4:0] DIV4_LAST  = 5'h01;
   localparam logic [4:0] DIV16_LAST = 5'h07;
   localparam logic [4:0] DIV64_LAST = 5'h1F;
   localparam logic [3:0] LAST_EDGE  = 4'hF;
   localparam logic [2:0] LAST_BIT   = 3'h7;
   localparam logic [1:0] DEB_OFF    = 2'h0;
   localparam logic [1:0] DEB_TWO    = 2'h1;
   localparam logic [2:0] DEB2_LAST  = 3'h1;
   localparam logic [2:0] DEB4_LAST  = 3'h3;

   typedef enum logic {ST_IDLE, ST_RUN} ssi_state_t;
endpackage

// [sim/ssi_peer.sv]
`timescale 1ns/1ps
module ssi_peer (
   input  wire logic       sck,
   input  wire logic       selN,
   input  wire logic       mosi,
   input  wire logic       go,
   input  wire logic [3:0] nBits,
   input  wire logic [7:0] txByte,
   output logic            peerClk,
   output logic            peerSelN,
   output logic            miso,
   output logic [7:0]      rxByte
);
   logic [7:0] sh;
   logic       first;
   logic       tog;
   initial begin
      peerClk = 1'b1;
      peerSelN = 1'b1;
      rxByte = 8'h00;
      sh = 8'h00;
      first = 1'b1;
      tog = 1'b0;
   end
   // Released data line keeps moving
   always #13 tog = ~tog;
   assign miso = selN ? tog : sh[7];
   always @(negedge selN) begin
      sh = txByte;
      first = 1'b1;
   end
   // Capture on rising, MSB first
   always @(posedge sck) if (!selN) rxByte <= {rxByte[6:0], mosi};
   // First falling edge only opens the frame
   always @(negedge sck) begin
      if (!selN && !first) sh <= {sh[6:0], 1'b0};
      first = 1'b0;
   end
   // Master role: clock runs only inside the frame
   always @(posedge go) begin
      #5 peerSelN = 1'b0;
      #64;
      repeat (nBits) begin
         peerClk = 1'b0;
         #32 peerClk = 1'b1;
         #32;
      end
      #64 peerSelN = 1'b1;
   end
endmodule

// [sim/ssi_core_tb_top.sv]
`timescale 1ns/1ps
module ssi_core_tb_top;
   logic        mclk = 1'b0;
   logic        rst = 1'b1;
   logic [4:0]  avsAddress = 5'h00;
   logic        avsRead = 1'b0;
   logic        avsWrite = 1'b0;
   logic [31:0] avsWritedata = 32'h0;
   logic [3:0]  avsByteenable = 4'hF;
   logic [31:0] avsReaddata;
   logic        avsWaitrequest;
   logic        serialClockOut, serialClockOe, serialOut, serialOutOe;
   logic        selectLineNOut, selectLineNOe, sclOut, sclOe, sdaOut, sdaOe;
   logic        sclPullUp, sdaPullUp, peerClk, peerSelN, miso;
   logic        sclLvl = 1'b1;
   logic        go = 1'b0;
   logic        tpm = 1'b0;
   logic [2:0]  tpmCnt = 3'h0;
   logic [3:0]  nBits = 4'h8;
   logic [7:0]  pTx = 8'h00;
   logic [7:0]  pRx, d, p, q;
   logic [8:0]  qe;
   logic [8:0]  expQ[$];
   int          failures = 0;
   int          nCompared = 0;
   int          seed;
   wire sck = serialClockOe ? serialClockOut : peerClk;
   wire selN = selectLineNOe ? selectLineNOut : peerSelN;
   wire mosi = serialOutOe ? serialOut : mclk;

   always #4 mclk = ~mclk;

   // Timer match pulse every eight clocks
   always @(posedge mclk) begin
      tpmCnt <= tpmCnt + 3'h1;
      tpm <= tpmCnt == 3'h7;
   end

   ssi_core uut (.mclk(mclk), .rst(rst), .ce(1'b1),
      .avs_address(avsAddress), .avs_read(avsRead), .avs_write(avsWrite),
      .avs_writedata(avsWritedata), .avs_byteenable(avsByteenable),
      .avs_readdata(avsReaddata), .avs_waitrequest(avsWaitrequest),
      .serialClockIn(sck), .serialClockOut(serialClockOut),
      .serialClockOe(serialClockOe), .serialIn(miso),
      .serialOut(serialOut), .serialOutOe(serialOutOe),
      .selectLineNIn(selN), .selectLineNOut(selectLineNOut),
      .selectLineNOe(selectLineNOe), .sclIn(sclLvl), .sclOut(sclOut),
      .sclOe(sclOe), .sdaIn(1'b1), .sdaOut(sdaOut), .sdaOe(sdaOe),
      .sclPullUp(sclPullUp), .sdaPullUp(sdaPullUp), .subClk(1'b0),
      .timerPeriodMatch(tpm));

   ssi_peer peer (.sck(sck), .selN(selN), .mosi(mosi), .go(go),
      .nBits(nBits), .txByte(pTx), .peerClk(peerClk),
      .peerSelN(peerSelN), .miso(miso), .rxByte(pRx));

   task automatic final_report();
      if (failures == 0 && nCompared > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   task automatic cmp(input logic [31:0] g, input logic [31:0] e);
      nCompared++;
      if (g !== e) begin
         failures++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask

   // One Avalon cycle, held until waitrequest is seen low
   task automatic busCyc(input logic [4:0] a, input logic [7:0] dv,
      input logic [3:0] b, input logic w, output logic [7:0] r);
      int i;
      avsAddress <= a;
      avsWritedata <= {24'h000000, dv};
      avsByteenable <= b;
      avsWrite <= w;
      avsRead <= !w;
      i = 0;
      do begin
         @(posedge mclk);
         i++;
      end while (avsWaitrequest !== 1'b0 && i < 50);
      if (avsWaitrequest !== 1'b0) begin
         failures++;
         final_report();
      end
      r = avsReaddata[7:0];
      avsWrite <= 1'b0;
      avsRead <= 1'b0;
      @(posedge mclk);
   endtask

   task automatic busWrite(input logic [4:0] a, input logic [7:0] dv);
      logic [7:0] r;
      busCyc(a, dv, 4'hF, 1'b1, r);
   endtask

   task automatic busRead(input logic [4:0] a, input logic [7:0] e);
      logic [7:0] r;
      expQ.push_back({1'b1, e});
      busCyc(a, 8'h00, 4'hF, 1'b0, r);
   endtask

   task automatic waitBit(input logic [4:0] a, input int b);
      logic [7:0] r;
      int i;
      r = 8'h00;
      for (i = 0; i < 200 && r[b] !== 1'b1; i++) begin
         expQ.push_back(9'h000);
         busCyc(a, 8'h00, 4'hF, 1'b0, r);
      end
      if (r[b] !== 1'b1) begin
         failures++;
         final_report();
      end
   endtask

   // Order: clock oe, out oe, select oe, clock, out, select
   task automatic chkPins(input logic [5:0] e, input logic [5:0] m);
      repeat (2) @(posedge mclk);
      @(negedge mclk);
      cmp({26'h0, m & {serialClockOe, serialOutOe, selectLineNOe,
         serialClockOut, serialOut, selectLineNOut}}, {26'h0, e & m});
      @(posedge mclk);
   endtask

   task automatic frame(input logic [3:0] n);
      nBits <= n;
      go <= 1'b1;
      @(posedge mclk);
      go <= 1'b0;
   endtask

   always @(negedge mclk) begin
      if (avsRead && avsWaitrequest === 1'b0 && expQ.size() > 0) begin
         qe = expQ.pop_front();
         if (qe[8]) cmp(avsReaddata, {24'h000000, qe[7:0]});
      end
   end

   initial begin
      seed = 32'h73BB4054;
      repeat (10) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      busRead(ssi_pkg::A_MODE, ssi_pkg::MODE_RST);
      busRead(ssi_pkg::A_STAT, ssi_pkg::STAT_RST);
      busRead(ssi_pkg::A_CTL2, ssi_pkg::CTL2_RST);
      busRead(5'h1C, 8'h00);
      chkPins(6'h07, 6'h3F);
      busWrite(ssi_pkg::A_MODE, 8'hF0);
      busRead(ssi_pkg::A_MODE, 8'hE0);
      busWrite(ssi_pkg::A_TOC, 8'h5A);
      busCyc(ssi_pkg::A_TOC, 8'hFF, 4'h0, 1'b1, q);
      busRead(ssi_pkg::A_TOC, 8'h5A);
      // Master, divide by 16, MSB first
      busWrite(ssi_pkg::A_MODE, 8'h20);
      busWrite(ssi_pkg::A_CTL2, 8'h2C);
      busWrite(ssi_pkg::A_MODE, 8'h22);
      chkPins(6'h3B, 6'h3F);
      busWrite(ssi_pkg::A_CTL2, 8'h0C);
      chkPins(6'h3F, 6'h3F);
      d = 8'($random(seed));
      p = 8'($random(seed));
      pTx <= p;
      busWrite(ssi_pkg::A_DATA, d);
      busWrite(ssi_pkg::A_DATA, ~d);
      busRead(ssi_pkg::A_CTL2, 8'h0E);
      waitBit(ssi_pkg::A_CTL2, ssi_pkg::B_TRF);
      busRead(ssi_pkg::A_DATA, p);
      cmp({24'h0, pRx}, {24'h0, d});
      busRead(ssi_pkg::A_CTL2, 8'h0F);
      busWrite(ssi_pkg::A_CTL2, 8'h0C);
      busRead(ssi_pkg::A_CTL2, 8'h0C);
      // Slave, full frame then aborted frame
      busWrite(ssi_pkg::A_MODE, 8'hA2);
      chkPins(6'h12, 6'h3A);
      d = 8'($random(seed));
      p = 8'($random(seed));
      pTx <= p;
      busWrite(ssi_pkg::A_DATA, d);
      frame(4'h8);
      waitBit(ssi_pkg::A_CTL2, ssi_pkg::B_TRF);
      busRead(ssi_pkg::A_DATA, p);
      cmp({24'h0, pRx}, {24'h0, d});
      busRead(ssi_pkg::A_CTL2, 8'h0D);
      busWrite(ssi_pkg::A_CTL2, 8'h0C);
      frame(4'h3);
      waitBit(ssi_pkg::A_MODE, ssi_pkg::B_ICF);
      busRead(ssi_pkg::A_MODE, 8'hA3);
      busRead(ssi_pkg::A_CTL2, 8'h0D);
      busRead(ssi_pkg::A_DATA, p);
      busWrite(ssi_pkg::A_CTL2, 8'h08);
      chkPins(6'h00, 6'h38);
      busWrite(ssi_pkg::A_CTL2, 8'h0C);
      busWrite(ssi_pkg::A_MODE, 8'h02);
      chkPins(6'h3F, 6'h3F);
      // Master clocked by timer pulses
      busWrite(ssi_pkg::A_MODE, 8'h80);
      busWrite(ssi_pkg::A_MODE, 8'h82);
      d = 8'($random(seed));
      p = 8'($random(seed));
      pTx <= p;
      busWrite(ssi_pkg::A_DATA, d);
      waitBit(ssi_pkg::A_CTL2, ssi_pkg::B_TRF);
      busRead(ssi_pkg::A_DATA, p);
      cmp({24'h0, pRx}, {24'h0, d});
      busWrite(ssi_pkg::A_CTL2, 8'h0C);
      busWrite(ssi_pkg::A_MODE, 8'h00);
      chkPins(6'h00, 6'h38);
      // Two-wire mode with pull-ups and debounce
      busWrite(ssi_pkg::A_PULL, 8'h03);
      busWrite(ssi_pkg::A_MODE, 8'hC6);
      chkPins(6'h00, 6'h38);
      cmp({28'h0, sclPullUp, sdaPullUp, sclOe, sdaOe}, 32'hC);
      busRead(ssi_pkg::A_PIN, 8'h03);
      sclLvl <= 1'b0;
      repeat (8) @(posedge mclk);
      busRead(ssi_pkg::A_PIN, 8'h02);
      busWrite(ssi_pkg::A_MODE, 8'hCA);
      sclLvl <= 1'b1;
      busRead(ssi_pkg::A_PIN, 8'h02);
      repeat (8) @(posedge mclk);
      busRead(ssi_pkg::A_PIN, 8'h03);
      repeat (4) @(posedge mclk);
      final_report();
   end
endmodule
